// >>> gdp_core.v
// gate driver protection configuration word with fault logic and apb slave
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "gdp_defs.vh"

module gdp_core #(
    parameter [`GDP_RTY_W-1:0] RETRY_CYCLES = `GDP_RETRY_CYC
) (
    input  wire                  pclk,
    input  wire                  presetn,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [`GDP_AW-1:0]    paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output wire                  pready,
    output wire                  pslverr,
    input  wire                  oc_cmp_16a,
    input  wire                  oc_cmp_24a,
    input  wire                  motor_supply_ov_34v,
    input  wire                  motor_supply_ov_22v,
    input  wire                  thermal_warn_in,
    output reg  [1:0]            slew_rate_sel,
    output reg                   slew_rate_valid,
    output reg                   driver_outputs_off,
    output reg                   fault_flag_out_low,
    output reg                   irq
);

    // overcurrent fault states
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_LATCH = 2'h1;
    localparam [1:0] ST_RETRY = 2'h2;

    // filter code to cycle count, rounded up
    function [`GDP_FLT_W-1:0] filt_limit;
        input [1:0] code;
        reg [31:0] cyc;
        begin
            case (code)
                2'h0:    cyc = `GDP_CEIL_CYC(`GDP_OCF_T0_NS);
                2'h1:    cyc = `GDP_CEIL_CYC(`GDP_OCF_T1_NS);
                2'h2:    cyc = `GDP_CEIL_CYC(`GDP_OCF_T2_NS);
                default: cyc = `GDP_CEIL_CYC(`GDP_OCF_T3_NS);
            endcase
            // counts fit the filter width; cut on purpose
            filt_limit = cyc[`GDP_FLT_W-1:0];
        end
    endfunction

    // address decode shared by read and write paths
    function addr_mapped;
        input [`GDP_AW-1:0] a;
        begin
            addr_mapped = (a == `GDP_ADDR_CFG) || (a == `GDP_ADDR_STAT) ||
                          (a == `GDP_ADDR_MASK) || (a == `GDP_ADDR_LIVE);
        end
    endfunction

    reg  [31:0]              cfg_word;
    reg  [`GDP_ST_W-1:0]     status;
    reg  [`GDP_ST_W-1:0]     mask;
    reg  [`GDP_IN_W-1:0]     sync_a;
    reg  [`GDP_IN_W-1:0]     sync_b;
    reg  [1:0]               oc_state;
    reg  [1:0]               next_oc_state;
    reg  [`GDP_RTY_W-1:0]    retry_cnt;
    reg                      ovp_prev;
    reg                      tw_prev;
    reg  [`GDP_ST_W-1:0]     next_status;
    reg  [31:0]              next_prdata;

    wire                     acc_wr;
    wire                     setup_rd;
    wire                     oc_raw;
    wire                     oc_det;
    wire                     ov_raw;
    wire                     ovp_active;
    wire                     tw_level;
    wire                     oc_fault;
    wire                     oc_event;
    wire                     ov_event;
    wire                     tw_event;
    wire                     oc_clr_wr;
    wire [`GDP_LV_W-1:0]     live;

    // zero wait states: read data is staged during the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_mapped(paddr);
    assign acc_wr   = psel & penable & pwrite & addr_mapped(paddr);
    assign setup_rd = psel & ~penable & ~pwrite;

    // two-stage synchronisers for the analog comparator levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= {`GDP_IN_W{1'b0}};
            sync_b <= {`GDP_IN_W{1'b0}};
        end else begin
            sync_a <= {thermal_warn_in, motor_supply_ov_22v,
                       motor_supply_ov_34v, oc_cmp_24a, oc_cmp_16a};
            sync_b <= sync_a;
        end
    end

    // threshold choice is digital: both comparators always run
    assign oc_raw = cfg_word[`GDP_OC_LVL] ? sync_b[`GDP_IN_OC24]
                                          : sync_b[`GDP_IN_OC16];

    gdp_filter u_oc_filter (
        .pclk     (pclk),
        .presetn  (presetn),
        .level_in (oc_raw),
        .limit    (filt_limit(cfg_word[`GDP_OCF_HI:`GDP_OCF_LO])),
        .accepted (oc_det)
    );

    // overvoltage level select and enable
    assign ov_raw     = cfg_word[`GDP_OV_LVL] ? sync_b[`GDP_IN_OV22]
                                              : sync_b[`GDP_IN_OV34];
    assign ovp_active = cfg_word[`GDP_OV_EN] & ov_raw;
    assign tw_level   = sync_b[`GDP_IN_TW];

    // events for the sticky status bits
    assign oc_fault  = (oc_state != ST_IDLE);
    assign oc_event  = (oc_state == ST_IDLE) & oc_det;
    assign ov_event  = ovp_active & ~ovp_prev;
    assign tw_event  = tw_level & ~tw_prev;
    assign oc_clr_wr = acc_wr & (paddr == `GDP_ADDR_STAT) &
                       pwdata[`GDP_ST_OC];

    // overcurrent response: latched or timed auto retry
    always @* begin
        next_oc_state = oc_state;
        case (oc_state)
            ST_IDLE: begin
                if (oc_det) begin
                    if (cfg_word[`GDP_OCR_HI:`GDP_OCR_LO] == `GDP_RSP_RETRY)
                        next_oc_state = ST_RETRY;
                    else
                        next_oc_state = ST_LATCH;
                end
            end
            ST_LATCH: begin
                // only a software clear with the condition gone releases it
                if (oc_clr_wr && !oc_det)
                    next_oc_state = ST_IDLE;
            end
            ST_RETRY: begin
                if (retry_cnt == {`GDP_RTY_W{1'b0}})
                    next_oc_state = ST_IDLE;
            end
            default: next_oc_state = ST_IDLE;
        endcase
    end

    // fault state and retry countdown
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_state  <= ST_IDLE;
            retry_cnt <= {`GDP_RTY_W{1'b0}};
        end else begin
            oc_state <= next_oc_state;
            if (oc_event)
                retry_cnt <= RETRY_CYCLES - {{(`GDP_RTY_W-1){1'b0}}, 1'b1};
            else if (oc_state == ST_RETRY &&
                     retry_cnt != {`GDP_RTY_W{1'b0}})
                retry_cnt <= retry_cnt - {{(`GDP_RTY_W-1){1'b0}}, 1'b1};
        end
    end

    // sticky status: a set in the clearing cycle survives
    always @* begin
        next_status = status;
        if (acc_wr && paddr == `GDP_ADDR_STAT)
            next_status = status & ~pwdata[`GDP_ST_W-1:0];
        if (oc_event)
            next_status[`GDP_ST_OC] = 1'b1;
        if (ov_event)
            next_status[`GDP_ST_OV] = 1'b1;
        if (tw_event)
            next_status[`GDP_ST_TW] = 1'b1;
    end

    // configuration, mask and status registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_word <= `GDP_CFG_RESET;
            mask     <= {`GDP_ST_W{1'b0}};
            status   <= {`GDP_ST_W{1'b0}};
            ovp_prev <= 1'b0;
            tw_prev  <= 1'b0;
        end else begin
            if (acc_wr && paddr == `GDP_ADDR_CFG)
                cfg_word <= pwdata; // all bits stored as written
            if (acc_wr && paddr == `GDP_ADDR_MASK)
                mask <= pwdata[`GDP_ST_W-1:0];
            status   <= next_status;
            ovp_prev <= ovp_active;
            tw_prev  <= tw_level;
        end
    end

    // live state view for software
    assign live = {fault_flag_out_low, slew_rate_valid, tw_level,
                   ovp_active, (oc_state == ST_RETRY), oc_fault};

    // read mux, staged in the setup cycle
    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `GDP_ADDR_CFG:  next_prdata = cfg_word;
            `GDP_ADDR_STAT: next_prdata[`GDP_ST_W-1:0] = status;
            `GDP_ADDR_MASK: next_prdata[`GDP_ST_W-1:0] = mask;
            `GDP_ADDR_LIVE: next_prdata[`GDP_LV_W-1:0] = live;
            default:        next_prdata = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup_rd)
            prdata <= next_prdata;
    end

    // pin and driver outputs from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_rate_sel      <= 2'h0;
            slew_rate_valid    <= 1'b0;
            driver_outputs_off <= 1'b0;
            fault_flag_out_low <= 1'b1;
            irq                <= 1'b0;
        end else begin
            slew_rate_sel   <= cfg_word[`GDP_SLEW_HI:`GDP_SLEW_LO];
            // codes below 2h carry no valid edge rate
            slew_rate_valid <=
                (cfg_word[`GDP_SLEW_HI:`GDP_SLEW_LO] == `GDP_SLEW_125) ||
                (cfg_word[`GDP_SLEW_HI:`GDP_SLEW_LO] == `GDP_SLEW_200);
            driver_outputs_off <= (next_oc_state != ST_IDLE) | ovp_active;
            fault_flag_out_low <= ~((next_oc_state != ST_IDLE) | ovp_active |
                                  (cfg_word[`GDP_TW_REP] & tw_level));
            irq <= |(next_status & mask);
        end
    end

endmodule // gdp_core

// >>> gdp_defs.vh
// constants for the gate driver protection configuration block
`ifndef GDP_DEFS_VH
`define GDP_DEFS_VH

// clock
`define GDP_CLK_NS        100
`define GDP_CEIL_CYC(t)   (((t) + `GDP_CLK_NS - 1) / `GDP_CLK_NS)

// register byte addresses
`define GDP_AW            8
`define GDP_ADDR_CFG      8'h00
`define GDP_ADDR_STAT     8'h04
`define GDP_ADDR_MASK     8'h08
`define GDP_ADDR_LIVE     8'h0C

// configuration word layout and reset value
`define GDP_CFG_RESET     32'h10228100
`define GDP_PARITY        31
`define GDP_SLEW_HI       27
`define GDP_SLEW_LO       26
`define GDP_OV_LVL        19
`define GDP_OV_EN         18
`define GDP_TW_REP        16
`define GDP_OCF_HI        13
`define GDP_OCF_LO        12
`define GDP_OC_LVL        10
`define GDP_OCR_HI        9
`define GDP_OCR_LO        8

// edge-rate and response codes
`define GDP_SLEW_125      2'h2
`define GDP_SLEW_200      2'h3
`define GDP_RSP_LATCH     2'h0
`define GDP_RSP_RETRY     2'h1

// overcurrent filter times in ns
`define GDP_OCF_T0_NS     200
`define GDP_OCF_T1_NS     600
`define GDP_OCF_T2_NS     1100
`define GDP_OCF_T3_NS     1600
`define GDP_FLT_W         5

// retry wait
`define GDP_RETRY_MS      500
`define GDP_RETRY_CYC     (`GDP_RETRY_MS * 1000000 / `GDP_CLK_NS)
`define GDP_RTY_W         23

// status / mask bits
`define GDP_ST_W          3
`define GDP_ST_OC         0
`define GDP_ST_OV         1
`define GDP_ST_TW         2

// live state bits
`define GDP_LV_W          6
`define GDP_LV_OCF        0
`define GDP_LV_RTY        1
`define GDP_LV_OVP        2
`define GDP_LV_TW         3
`define GDP_LV_SLEWOK     4
`define GDP_LV_PIN        5

// synchronised input positions
`define GDP_IN_W          5
`define GDP_IN_OC16       0
`define GDP_IN_OC24       1
`define GDP_IN_OV34       2
`define GDP_IN_OV22       3
`define GDP_IN_TW         4

`endif

// >>> gdp_filter.v
// persistence filter: accepts a level after a programmed run of cycles
`timescale 1ns/10ps
`include "gdp_defs.vh"

module gdp_filter (
    input  wire                  pclk,
    input  wire                  presetn,
    input  wire                  level_in,
    input  wire [`GDP_FLT_W-1:0] limit,
    output reg                   accepted
);

    reg  [`GDP_FLT_W-1:0] run_cnt;
    wire [`GDP_FLT_W:0]   run_inc;

    assign run_inc = {1'b0, run_cnt} + {{`GDP_FLT_W{1'b0}}, 1'b1};

    // count consecutive high samples, saturating; any low sample restarts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt  <= {`GDP_FLT_W{1'b0}};
            accepted <= 1'b0;
        end else if (!level_in) begin
            run_cnt  <= {`GDP_FLT_W{1'b0}};
            accepted <= 1'b0;
        end else begin
            if (!run_inc[`GDP_FLT_W])
                run_cnt <= run_inc[`GDP_FLT_W-1:0];
            accepted <= (run_inc >= {1'b0, limit});
        end
    end

endmodule // gdp_filter

// >>> gdp_chk_asserts.sv
// concurrent checks on the protection configuration block ports
`timescale 1ns/10ps
`include "gdp_defs.vh"
module gdp_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        motor_supply_ov_34v,
    input wire        motor_supply_ov_22v,
    input wire        thermal_warn_in,
    input wire [1:0]  slew_rate_sel,
    input wire        slew_rate_valid,
    input wire        driver_outputs_off,
    input wire        fault_flag_out_low
);
    reg  [31:0] cfg;
    wire        wr_cfg;
    wire        ovp;
    wire        twp;
    // shadow word so pin behaviour can be tied to the fields
    assign wr_cfg = psel & penable & pwrite & (paddr == 8'h00);
    assign ovp = cfg[18] & (cfg[19] ? motor_supply_ov_22v : motor_supply_ov_34v);
    assign twp = cfg[16] & thermal_warn_in;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cfg <= `GDP_CFG_RESET;
        else if (wr_cfg)
            cfg <= pwdata;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // four samples cover the two sync flops and the output flop
    sequence s_ovp_hold; ovp [*4]; endsequence
    sequence s_tw_hold; twp [*4]; endsequence
    a_slew_valid: assert property (
        slew_rate_valid == slew_rate_sel[1]) else $error("slew valid wrong");
    a_slew_follow: assert property (
        wr_cfg |-> ##2 slew_rate_sel == $past(pwdata[27:26], 2))
        else $error("slew code not applied");
    a_ovp_trip: assert property (
        s_ovp_hold |-> driver_outputs_off && !fault_flag_out_low)
        else $error("overvoltage not acted on");
    a_tw_pin: assert property (
        s_tw_hold |-> !fault_flag_out_low) else $error("warning not on pin");
    a_off_pin: assert property (
        driver_outputs_off |-> !fault_flag_out_low) else $error("pin not low");
    a_ready_high: assert property (
        pready) else $error("wait state inserted");
    a_err_unmapped: assert property (
        pslverr == (psel && penable && (paddr > 8'h0C || paddr[1:0] != 2'h0)))
        else $error("slave error wrong");
    a_cfg_read: assert property (
        psel && !penable && !pwrite && paddr == 8'h00 |=> prdata == $past(cfg))
        else $error("config read wrong");
endmodule // gdp_chk

bind gdp_core gdp_chk u_gdp_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .motor_supply_ov_34v(motor_supply_ov_34v),
    .motor_supply_ov_22v(motor_supply_ov_22v),
    .thermal_warn_in(thermal_warn_in), .slew_rate_sel(slew_rate_sel),
    .slew_rate_valid(slew_rate_valid),
    .driver_outputs_off(driver_outputs_off),
    .fault_flag_out_low(fault_flag_out_low)
);

// >>> test_gate_driver_protection_config.sv
// self-checking bench for the protection configuration block
`timescale 1ns/10ps
`include "gdp_defs.vh"
module test_gate_driver_protection_config;
    localparam [22:0] RC = 23'd20;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rd;
    reg  [4:0]  cmp = 5'h0; // 16a, 24a, 34v, 22v, warning
    reg         er;
    wire [31:0] prdata;
    wire [1:0]  slew_rate_sel;
    wire        pready, pslverr, slew_rate_valid, driver_outputs_off;
    wire        fault_flag_out_low, irq;
    int         n_fail = 0, cmp_count = 0, cnt, n;
    // overvoltage cases: field bits, comparator driven, pin expected low
    reg  [2:0]  ovc [4] = '{3'b000, 3'b010, 3'b010, 3'b110};
    int         pn [4] = '{2, 3, 2, 3};
    reg         ovx [4] = '{0, 0, 1, 1};
    gdp_core #(.RETRY_CYCLES(RC)) u_gdp_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oc_cmp_16a(cmp[0]),
        .oc_cmp_24a(cmp[1]), .motor_supply_ov_34v(cmp[2]),
        .motor_supply_ov_22v(cmp[3]), .thermal_warn_in(cmp[4]),
        .slew_rate_sel(slew_rate_sel), .slew_rate_valid(slew_rate_valid),
        .driver_outputs_off(driver_outputs_off),
        .fault_flag_out_low(fault_flag_out_low), .irq(irq));
    always #50 pclk = ~pclk;
    task check(input [31:0] seen, input [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // config word with reserved bits at their reset values
    function [31:0] cw(input [1:0] s, input [2:0] ov, input [1:0] f,
                       input l, input [1:0] r);
        cw = {4'h1, s, 6'h02, ov[2:1], 1'b1, ov[0], 2'h2, f, 1'b0, l, r,
              8'h00};
    endfunction
    // filter lengths in cycles at 100 ns
    function int nf(input int c);
        nf = (c == 0) ? 2 : (c == 1) ? 6 : (c == 2) ? 11 : 16;
    endfunction
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        n_fail++;
        print_verdict;
    end
    initial begin
        tick(5);
        presetn <= 1;
        apb(0, 8'h00, 0);
        check(rd, `GDP_CFG_RESET);
        apb(0, 8'h10, 0);
        check(er, 1);
        check(rd, 0);
        apb(1, 8'h08, 32'h7);
        for (n = 0; n < 4; n++) begin
            apb(1, 8'h00, cw(n[1:0], 0, 0, 0, 1));
            tick(2);
            check(slew_rate_sel, n);
            check(slew_rate_valid, n >= 2);
        end
        // short pulse ignored, long one latches until cleared
        for (n = 0; n < 4; n++) begin
            apb(1, 8'h00, cw(2'h2, 0, n[1:0], 0, 0));
            cmp[0] <= 1;
            tick(nf(n) - 1);
            cmp[0] <= 0;
            tick(6);
            check(fault_flag_out_low, 1);
            cmp[0] <= 1;
            for (cnt = 0; fault_flag_out_low !== 1'b0 && cnt < 30; cnt++) tick(1);
            check(cnt >= nf(n) && cnt <= nf(n) + 5, 1);
            cmp[0] <= 0;
            tick(10);
            check({irq, fault_flag_out_low}, 2'b10);
            apb(0, 8'h04, 0);
            check(rd[0], 1);
            apb(1, 8'h04, 32'h1);
            tick(3);
            check({irq, fault_flag_out_low}, 2'b01);
        end
        // 24 A level ignores the 16 A comparator; retry clears itself
        apb(1, 8'h00, cw(2'h2, 0, 0, 1, 1));
        cmp[0] <= 1;
        tick(10);
        check(fault_flag_out_low, 1);
        cmp[1] <= 1;
        tick(8);
        cmp <= 5'h0;
        check(fault_flag_out_low, 0);
        for (cnt = 0; fault_flag_out_low !== 1'b1 && cnt < 99; cnt++) tick(1);
        check(cnt >= RC - 8 && cnt <= RC + 4, 1);
        for (n = 0; n < 4; n++) begin
            apb(1, 8'h00, cw(2'h2, ovc[n], 0, 0, 1));
            cmp[pn[n]] <= 1;
            tick(6);
            check(fault_flag_out_low, !ovx[n]);
            check(driver_outputs_off, ovx[n]);
            cmp <= 5'h0;
            tick(4);
        end
        // warning with reporting off and on; masked irq stays low
        apb(1, 8'h04, 32'h7);
        apb(1, 8'h08, 32'h0);
        for (n = 0; n < 2; n++) begin
            apb(1, 8'h00, cw(2'h2, {2'b00, n[0]}, 0, 0, 1));
            cmp[4] <= 1;
            tick(6);
            check(fault_flag_out_low, !n);
            check(irq, 0);
            cmp[4] <= 0;
            tick(4);
        end
        apb(0, 8'h04, 0);
        check(rd, 32'h4);
        apb(1, 8'h08, 32'h4);
        tick(2);
        check(irq, 1);
        print_verdict;
    end
endmodule // test_gate_driver_protection_config
